// ==== rtl/fpwdt_pkg.sv ====
// constants and types shared by the fixed-period watchdog
package fpwdt_pkg;
  localparam int unsigned CLK_FREQ_HZ     = 100_000_000;
  localparam int unsigned TIMEOUT_MS      = 800;
  localparam longint unsigned TIMEOUT_CYC_L = (longint'(CLK_FREQ_HZ) * TIMEOUT_MS) / 1000;
  localparam int unsigned TIMEOUT_CYCLES  = int'(TIMEOUT_CYC_L);
  localparam int          CNT_W           = 27;
  localparam int unsigned SYS_RST_MS      = 0;
  localparam logic [7:0]  RST_PULSE_CYC   = 8'h10;
  localparam logic [CNT_W-1:0] CNT_ZERO   = {CNT_W{1'b0}};
  localparam logic [CNT_W-1:0] CNT_ONE    = {{(CNT_W-1){1'b0}}, 1'b1};
  typedef enum logic [1:0] {
    FPWDT_IDLE,
    FPWDT_RUN,
    FPWDT_BITE
  } fpwdt_state_t;
endpackage : fpwdt_pkg

// ==== rtl/fpwdt_sync.sv ====
// two-flop synchroniser for one level
`timescale 1ns/1ns
module fpwdt_sync (
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = clk_en_i ? async_i : meta;
    next_sync = clk_en_i ? meta : sync_o;
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta   <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta   <= next_meta;
      sync_o <= next_sync;
    end
  end
endmodule : fpwdt_sync

// ==== rtl/fpwdt_top.sv ====
// fixed-period watchdog with system reset request and sticky reset cause
//
// Summary of operation
// - timeout is a fixed 0.8 s; no software path changes it.
// - running watchdog with no refresh inside 0.8 s requests full system reset.
// - software arms and disarms; when armed it must refresh before timeout.
// - reset-cause flag survives the watchdog reset and reads back to software.
`timescale 1ns/1ns
module fpwdt_top
  import fpwdt_pkg::*;
#(
  // build-time only, no software path reaches it; a bench may shorten it
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYCLES
)
(
  input  wire logic sys_clk_i,
  input  wire logic rst_n_i,
  input  wire logic clk_en_i,
  input  wire logic watchdog_arm_call_i,
  input  wire logic watchdog_disarm_call_i,
  input  wire logic watchdog_kick_call_i,
  input  wire logic cause_clear_i,
  output logic      last_reset_cause_query_o,
  output logic      armed_o,
  output logic      sys_reset_req_o
);
  import fpwdt_pkg::*;

  // rst_n_i is power-on only; the bite is issued as sys_reset_req_o and
  // must not feed back into rst_n_i, otherwise the cause flag is lost

  fpwdt_state_t      state;
  fpwdt_state_t      next_state;
  logic [CNT_W-1:0]  count;
  logic [CNT_W-1:0]  next_count;
  logic [7:0]        pulse;
  logic [7:0]        next_pulse;
  logic              next_cause;
  logic              next_armed;
  logic              next_req;
  logic              cause_clr_s;

  // software clear may come from an unrelated domain during boot
  fpwdt_sync u_clr_sync (
    .sys_clk_i (sys_clk_i),
    .rst_n_i   (rst_n_i),
    .clk_en_i  (clk_en_i),
    .async_i   (cause_clear_i),
    .sync_o    (cause_clr_s)
  );

  localparam logic [CNT_W-1:0] LAST_CNT = CNT_W'(TIMEOUT_CYC - 1);

  always_comb begin
    next_state = state;
    next_count = count;
    next_pulse = pulse;
    next_cause = last_reset_cause_query_o;
    next_armed = armed_o;
    next_req   = sys_reset_req_o;
    if (clk_en_i) begin
      if (cause_clr_s) begin
        next_cause = 1'b0;
      end
      case (state)
        FPWDT_IDLE: begin
          next_count = CNT_ZERO;
          if (watchdog_arm_call_i && !watchdog_disarm_call_i) begin
            next_state = FPWDT_RUN;
            next_armed = 1'b1;
          end
        end
        FPWDT_RUN: begin
          if (watchdog_disarm_call_i) begin
            next_state = FPWDT_IDLE;
            next_armed = 1'b0;
            next_count = CNT_ZERO;
          end else if (watchdog_kick_call_i) begin
            next_count = CNT_ZERO;
          end else if (count == LAST_CNT) begin
            next_state = FPWDT_BITE;
            next_req   = 1'b1;
            next_cause = 1'b1;
            next_pulse = RST_PULSE_CYC;
            next_count = CNT_ZERO;
          end else begin
            next_count = count + CNT_ONE;
          end
        end
        FPWDT_BITE: begin
          // a bite wins over a clear that lands in the same cycle
          next_cause = 1'b1;
          if (pulse == 8'h01) begin
            next_state = FPWDT_IDLE;
            next_req   = 1'b0;
            next_armed = 1'b0;
            next_pulse = 8'h00;
          end else begin
            next_pulse = pulse - 8'h01;
          end
        end
        default: begin
          next_state = FPWDT_IDLE;
          next_armed = 1'b0;
          next_req   = 1'b0;
          next_count = CNT_ZERO;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state                    <= FPWDT_IDLE;
      count                    <= CNT_ZERO;
      pulse                    <= 8'h00;
      last_reset_cause_query_o <= 1'b0;
      armed_o                  <= 1'b0;
      sys_reset_req_o          <= 1'b0;
    end else begin
      state                    <= next_state;
      count                    <= next_count;
      pulse                    <= next_pulse;
      last_reset_cause_query_o <= next_cause;
      armed_o                  <= next_armed;
      sys_reset_req_o          <= next_req;
    end
  end
endmodule : fpwdt_top

// ==== verification/fpwdt_sva.sv ====
// port assertions for the fixed-period watchdog
`timescale 1ns/1ns
module fpwdt_sva
  import fpwdt_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = TIMEOUT_CYCLES
)
(
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  input wire logic watchdog_arm_call_i,
  input wire logic watchdog_disarm_call_i,
  input wire logic watchdog_kick_call_i,
  input wire logic cause_clear_i,
  input wire logic last_reset_cause_query_o,
  input wire logic armed_o,
  input wire logic sys_reset_req_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  // loose by a few cycles: only an early bite is a real fault here
  logic [CNT_W:0] idle_cnt;
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
    if (!rst_n_i) idle_cnt <= '0;
    else if (!armed_o || (watchdog_kick_call_i && clk_en_i)) idle_cnt <= '0;
    else if (clk_en_i) idle_cnt <= idle_cnt + 1'h1;
  chk_arm_rise: assert property (!armed_o && !sys_reset_req_o && clk_en_i && watchdog_arm_call_i
    && !watchdog_disarm_call_i |=> armed_o) else $error("arm not taken");
  chk_disarm_drop: assert property (armed_o && !sys_reset_req_o && clk_en_i && watchdog_disarm_call_i
    |=> !armed_o) else $error("disarm not taken");
  chk_no_early_bite: assert property ($rose(sys_reset_req_o) |-> idle_cnt > TIMEOUT_CYC - 4)
    else $error("reset request before timeout");
  chk_bite_cause: assert property ($rose(sys_reset_req_o) |-> ##1 last_reset_cause_query_o)
    else $error("cause not set on bite");
  chk_bite_width: assert property ($rose(sys_reset_req_o) |-> sys_reset_req_o [*8])
    else $error("reset request too short");
endmodule : fpwdt_sva

// ==== verification/fpwdt_bench.sv ====
// self-checking bench for the fixed-period watchdog
`timescale 1ns/1ns
module fpwdt_bench;
  import fpwdt_pkg::*;
  logic       sys_clk_i = 1'h0;
  logic       rst_n_i   = 1'h0;
  logic       clk_en_i  = 1'h1;
  logic [3:0] cmd       = 4'h0;
  logic       cause, armed, req;
  int         n_fail    = 0;
  int         checks    = 0;
  // shortened interval so that a bite fits inside the run
  localparam int unsigned SHORT_TO = 200;
  always #5 sys_clk_i = ~sys_clk_i;
  fpwdt_top #(.TIMEOUT_CYC(SHORT_TO)) uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .watchdog_arm_call_i(cmd[0]),
    .watchdog_disarm_call_i(cmd[1]), .watchdog_kick_call_i(cmd[2]), .cause_clear_i(cmd[3]),
    .last_reset_cause_query_o(cause), .armed_o(armed), .sys_reset_req_o(req));
  task automatic chk(input string what, input logic seen, input logic exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %b seen %b", what, exp, seen);
    end
  endtask : chk
  // one-cycle request: raised after an edge, dropped at the edge that takes it
  task automatic pulse(input int b);
    @(posedge sys_clk_i) cmd[b] <= 1'h1;
    @(posedge sys_clk_i) cmd[b] <= 1'h0;
    #1;
  endtask : pulse
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : complete_run
  task automatic t_idle();
    chk("cause", cause, 1'h0);
    pulse(2);
    chk("armed", armed, 1'h0);
    $display("idle test done");
  endtask : t_idle
  task automatic t_kick_run();
    pulse(0);
    chk("armed", armed, 1'h1);
    repeat (6) begin
      repeat (SHORT_TO - 50) @(posedge sys_clk_i);
      pulse(2);
      chk("req", req, 1'h0);
    end
    $display("kick test done");
  endtask : t_kick_run
  task automatic t_freeze_disarm();
    @(posedge sys_clk_i) clk_en_i <= 1'h0;
    pulse(1);
    chk("armed", armed, 1'h1);
    @(posedge sys_clk_i) clk_en_i <= 1'h1;
    pulse(1);
    chk("armed", armed, 1'h0);
    chk("cause", cause, 1'h0);
    $display("disarm test done");
  endtask : t_freeze_disarm
  task automatic t_bite();
    pulse(0);
    repeat (SHORT_TO - 1) @(posedge sys_clk_i);
    #1;
    chk("req", req, 1'h0);
    @(posedge sys_clk_i);
    #1;
    chk("req", req, 1'h1);
    chk("cause", cause, 1'h1);
    repeat (int'(RST_PULSE_CYC) - 1) @(posedge sys_clk_i);
    #1;
    chk("req", req, 1'h1);
    @(posedge sys_clk_i);
    #1;
    chk("req", req, 1'h0);
    chk("armed", armed, 1'h0);
    chk("cause", cause, 1'h1);
    pulse(3);
    repeat (2) @(posedge sys_clk_i);
    #1;
    chk("cause", cause, 1'h0);
    $display("bite test done");
  endtask : t_bite
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rst_n_i <= 1'h1;
    t_idle();
    t_kick_run();
    t_freeze_disarm();
    t_bite();
    complete_run();
  end
  initial begin
    #200000;
    n_fail++;
    complete_run();
  end
endmodule : fpwdt_bench
bind fpwdt_top fpwdt_sva #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.sys_clk_i, .rst_n_i, .clk_en_i, .watchdog_arm_call_i,
  .watchdog_disarm_call_i,
  .watchdog_kick_call_i, .cause_clear_i, .last_reset_cause_query_o, .armed_o, .sys_reset_req_o);
